// ---- rtl/seg_char_encoder.v ----
`timescale 1ns/1ns
`include "status_display_regs.vh"

module seg_char_encoder (
	// Character in
	input  wire [`CH_W-1:0]  char_in,
	// Segments out
	output reg  [`SEG_W-1:0] seg_out
);

	always @* begin
		case (char_in)
			4'h0: seg_out = `SEG_0;
			4'h1: seg_out = `SEG_1;
			4'h2: seg_out = `SEG_2;
			4'h3: seg_out = `SEG_3;
			4'h4: seg_out = `SEG_4;
			4'h5: seg_out = `SEG_5;
			4'h6: seg_out = `SEG_6;
			4'h7: seg_out = `SEG_7;
			4'h8: seg_out = `SEG_8;
			4'h9: seg_out = `SEG_9;
			`CH_E: seg_out = `SEG_E;
			`CH_R: seg_out = `SEG_R;
			`CH_DASH: seg_out = `SEG_DASH;
			default: seg_out = `SEG_BLANK;
		endcase
	end

endmodule

// ---- rtl/status_display_regs.vh ----
`ifndef STATUS_DISPLAY_REGS_VH
`define STATUS_DISPLAY_REGS_VH

// Timing
`define CLK_FREQ_KHZ      50000
`define FRAME_TIME_MS     1000
`define TICK_W            26

// Error fields
`define ERR_NUM_W         7
`define ERR_ID_W          16
`define ERR_TIME_W        32
`define HIST_DEPTH        20
`define HIST_DEPTH_W      6'd20
`define HIST_IDX_W        5
`define HIST_LAST         5'd19

// Character codes fed to the digit encoder
`define CH_W              4
`define CH_0              4'h0
`define CH_2              4'h2
`define CH_3              4'h3
`define CH_4              4'h4
`define CH_5              4'h5
`define CH_6              4'h6
`define CH_8              4'h8
`define CH_E              4'hA
`define CH_R              4'hB
`define CH_DASH           4'hC
`define CH_BLANK          4'hF

// Segment patterns, bit order g f e d c b a, lit = 1
`define SEG_W             7
`define SEG_0             7'h3F
`define SEG_1             7'h06
`define SEG_2             7'h5B
`define SEG_3             7'h4F
`define SEG_4             7'h66
`define SEG_5             7'h6D
`define SEG_6             7'h7D
`define SEG_7             7'h07
`define SEG_8             7'h7F
`define SEG_9             7'h6F
`define SEG_E             7'h79
`define SEG_R             7'h50
`define SEG_DASH          7'h40
`define SEG_BLANK         7'h00

// Error frame states, one-hot
`define FR_W              3
`define FR_BANNER         3'h1
`define FR_NUMBER         3'h2
`define FR_LOCATION       3'h4

`endif

// ---- rtl/status_error_display_sequencer.v ----
`timescale 1ns/1ns
`include "status_display_regs.vh"

module status_error_display_sequencer #(
	parameter [`TICK_W-1:0] FRAME_CYCLES = `FRAME_TIME_MS * `CLK_FREQ_KHZ
) (
	// Clock and reset
	input  wire                    sys_clk_in,
	input  wire                    sys_rst_in,
	// Drive state
	input  wire                    init_busy_in,
	input  wire                    dc_link_ok_in,
	input  wire                    stage_ready_in,
	input  wire                    switched_on_in,
	input  wire                    op_enabled_in,
	input  wire                    quick_stop_in,
	input  wire                    fault_reaction_in,
	input  wire                    safe_torque_off_in,
	input  wire                    stage_active_in,
	// Error and warning events
	input  wire                    err_valid_in,
	input  wire                    warn_valid_in,
	input  wire                    err_ack_in,
	input  wire                    supply_reset_only_error_in,
	input  wire                    err_cause_present_in,
	input  wire [`ERR_NUM_W-1:0]   err_number_in,
	input  wire [`ERR_NUM_W-1:0]   err_location_in,
	input  wire [`ERR_ID_W-1:0]    err_cause_in,
	input  wire [`ERR_ID_W-1:0]    err_remedy_in,
	input  wire [`ERR_ID_W-1:0]    err_id_in,
	input  wire [`ERR_ID_W-1:0]    err_comment_in,
	input  wire [`ERR_TIME_W-1:0]  err_time_in,
	// History read
	input  wire [`HIST_IDX_W-1:0]  hist_index_in,
	// Display
	output reg  [`SEG_W-1:0]       seg_tens_out,
	output reg  [`SEG_W-1:0]       seg_ones_out,
	output reg                     dp_tens_out,
	output reg                     dp_ones_out,
	// Error status
	output wire                    error_pending_out,
	output wire                    supply_reset_only_error_out,
	// Diagnostic record
	output reg  [`ERR_ID_W-1:0]    rec_cause_out,
	output reg  [`ERR_ID_W-1:0]    rec_remedy_out,
	output reg  [`ERR_ID_W-1:0]    rec_id_out,
	output reg  [`ERR_NUM_W-1:0]   rec_location_out,
	output reg  [`ERR_TIME_W-1:0]  rec_time_out,
	output reg  [`ERR_ID_W-1:0]    rec_comment_out,
	// History entry
	output reg                     hist_valid_out,
	output reg  [`ERR_NUM_W-1:0]   hist_number_out,
	output reg  [`ERR_NUM_W-1:0]   hist_location_out,
	output wire [`HIST_IDX_W-1:0]  hist_count_out
);

	// Binary 0..99 to two decimal digits; values above 99 show tens as 9
	function [2*`CH_W-1:0] to_decimal;
		input [`ERR_NUM_W-1:0] value;
		reg   [`ERR_NUM_W-1:0] tens;
		reg   [`ERR_NUM_W-1:0] ones;
		begin
			tens       = (value > 7'd99) ? 7'd9 : value / 7'd10;
			ones       = value - tens * 7'd10;
			to_decimal = {tens[`CH_W-1:0], ones[`CH_W-1:0]};
		end
	endfunction

	// Error latch
	reg                   pending_ff;
	reg                   dotted_ff;
	reg [`ERR_NUM_W-1:0]  number_ff;
	reg [`ERR_NUM_W-1:0]  location_ff;
	reg                   nxt_pending;
	reg                   nxt_dotted;
	reg [`ERR_NUM_W-1:0]  nxt_number;
	reg [`ERR_NUM_W-1:0]  nxt_location;
	wire                  relatch;
	wire                  new_error;

	// Dotted error with live cause comes back right after reset release
	assign relatch   = ~pending_ff & err_cause_present_in & supply_reset_only_error_in;
	assign new_error = err_valid_in | relatch;

	always @* begin
		nxt_pending  = pending_ff;
		nxt_dotted   = dotted_ff;
		nxt_number   = number_ff;
		nxt_location = location_ff;
		if (new_error) begin
			// Set wins over a same-cycle acknowledge
			nxt_pending  = 1'b1;
			nxt_dotted   = supply_reset_only_error_in;
			nxt_number   = err_number_in;
			nxt_location = err_location_in;
		end else if (err_ack_in && !dotted_ff) begin
			nxt_pending  = 1'b0;
		end
	end

	always @(posedge sys_clk_in) begin
		if (sys_rst_in) begin
			pending_ff  <= 1'b0;
			dotted_ff   <= 1'b0;
			number_ff   <= 7'h00;
			location_ff <= 7'h00;
		end else begin
			pending_ff  <= nxt_pending;
			dotted_ff   <= nxt_dotted;
			number_ff   <= nxt_number;
			location_ff <= nxt_location;
		end
	end

	assign error_pending_out           = pending_ff;
	assign supply_reset_only_error_out = dotted_ff;

	// One second prescaler and error frame sequencing
	reg [`TICK_W-1:0] tick_cnt_ff;
	reg [`FR_W-1:0]   frame_ff;
	reg [`FR_W-1:0]   nxt_frame;
	reg               blink_ff;
	wire              tick;

	assign tick = (tick_cnt_ff == FRAME_CYCLES - 26'h1);

	always @* begin
		case (frame_ff)
			`FR_BANNER:   nxt_frame = `FR_NUMBER;
			`FR_NUMBER:   nxt_frame = `FR_LOCATION;
			`FR_LOCATION: nxt_frame = `FR_BANNER;
			default:      nxt_frame = `FR_BANNER;
		endcase
	end

	always @(posedge sys_clk_in) begin
		if (sys_rst_in) begin
			tick_cnt_ff <= 26'h0;
			frame_ff    <= `FR_BANNER;
			blink_ff    <= 1'b0;
		end else if (new_error) begin
			// Fresh error always starts on the banner
			tick_cnt_ff <= 26'h0;
			frame_ff    <= `FR_BANNER;
			blink_ff    <= blink_ff;
		end else if (tick) begin
			tick_cnt_ff <= 26'h0;
			frame_ff    <= pending_ff ? nxt_frame : `FR_BANNER;
			blink_ff    <= ~blink_ff;
		end else begin
			tick_cnt_ff <= tick_cnt_ff + 26'h1;
			frame_ff    <= frame_ff;
			blink_ff    <= blink_ff;
		end
	end

	// Character selection
	reg  [`CH_W-1:0]   char_tens;
	reg  [`CH_W-1:0]   char_ones;
	reg                dp_tens;
	reg                dp_ones;
	wire [2*`CH_W-1:0] num_dec;
	wire [2*`CH_W-1:0] loc_dec;
	wire               flash;

	assign num_dec = to_decimal(number_ff);
	assign loc_dec = to_decimal(location_ff);
	// Flash follows the one second tick, so a 2 s period
	assign flash   = stage_active_in & blink_ff;

	always @* begin
		char_tens = `CH_BLANK;
		char_ones = `CH_BLANK;
		dp_tens   = 1'b0;
		dp_ones   = 1'b0;
		if (init_busy_in) begin
			char_tens = `CH_DASH;
			char_ones = `CH_8;
		end else if (pending_ff) begin
			case (frame_ff)
				`FR_NUMBER: begin
					char_tens = num_dec[2*`CH_W-1:`CH_W];
					char_ones = num_dec[`CH_W-1:0];
				end
				`FR_LOCATION: begin
					char_tens = loc_dec[2*`CH_W-1:`CH_W];
					char_ones = loc_dec[`CH_W-1:0];
				end
				default: begin
					char_tens = `CH_E;
					char_ones = `CH_R;
					dp_ones   = dotted_ff;
				end
			endcase
		end else if (fault_reaction_in) begin
			char_tens = `CH_8;
			char_ones = `CH_8;
			dp_ones   = flash;
		end else if (quick_stop_in) begin
			char_tens = `CH_DASH;
			char_ones = `CH_6;
			dp_ones   = flash;
		end else if (op_enabled_in) begin
			char_tens = `CH_8;
			char_ones = `CH_5;
			dp_ones   = flash;
		end else if (switched_on_in) begin
			char_tens = `CH_4;
			dp_ones   = flash;
		end else if (stage_ready_in) begin
			char_tens = `CH_8;
			char_ones = `CH_3;
		end else if (dc_link_ok_in) begin
			char_tens = `CH_5;
			char_ones = `CH_2;
			dp_tens   = 1'b1;
			dp_ones   = safe_torque_off_in;
		end else begin
			char_tens = `CH_5;
			dp_tens   = safe_torque_off_in;
		end
	end

	wire [`SEG_W-1:0] seg_tens;
	wire [`SEG_W-1:0] seg_ones;

	seg_char_encoder u_enc_tens (
		.char_in (char_tens),
		.seg_out (seg_tens)
	);

	seg_char_encoder u_enc_ones (
		.char_in (char_ones),
		.seg_out (seg_ones)
	);

	// Registered display drive
	always @(posedge sys_clk_in) begin
		if (sys_rst_in) begin
			seg_tens_out <= `SEG_8;
			seg_ones_out <= `SEG_8;
			dp_tens_out  <= 1'b0;
			dp_ones_out  <= 1'b0;
		end else begin
			seg_tens_out <= seg_tens;
			seg_ones_out <= seg_ones;
			dp_tens_out  <= dp_tens;
			dp_ones_out  <= dp_ones;
		end
	end

	// Diagnostic record for the latest error or warning
	always @(posedge sys_clk_in) begin
		if (sys_rst_in) begin
			rec_cause_out    <= 16'h0000;
			rec_remedy_out   <= 16'h0000;
			rec_id_out       <= 16'h0000;
			rec_location_out <= 7'h00;
			rec_time_out     <= 32'h0000_0000;
			rec_comment_out  <= 16'h0000;
		end else if (err_valid_in || warn_valid_in) begin
			rec_cause_out    <= err_cause_in;
			rec_remedy_out   <= err_remedy_in;
			rec_id_out       <= err_id_in;
			rec_location_out <= err_location_in;
			rec_time_out     <= err_time_in;
			rec_comment_out  <= err_comment_in;
		end
	end

	// History ring, newest at index 0
	reg [2*`ERR_NUM_W-1:0]  hist_mem [0:`HIST_DEPTH-1];
	reg [`HIST_IDX_W-1:0]   wr_ptr_ff;
	reg [`HIST_IDX_W-1:0]   count_ff;
	reg [`HIST_IDX_W:0]     rd_sum;
	reg [`HIST_IDX_W-1:0]   rd_addr;

	always @* begin
		rd_sum = {1'b0, wr_ptr_ff} + {1'b0, `HIST_LAST} - {1'b0, hist_index_in};
		if (rd_sum >= `HIST_DEPTH_W) begin
			rd_sum = rd_sum - `HIST_DEPTH_W;
		end
		rd_addr = rd_sum[`HIST_IDX_W-1:0];
	end

	always @(posedge sys_clk_in) begin
		if (err_valid_in) begin
			hist_mem[wr_ptr_ff] <= {err_number_in, err_location_in};
		end
	end

	always @(posedge sys_clk_in) begin
		if (sys_rst_in) begin
			wr_ptr_ff <= 5'h00;
			count_ff  <= 5'h00;
		end else if (err_valid_in) begin
			// Oldest entry is overwritten once full
			wr_ptr_ff <= (wr_ptr_ff == `HIST_LAST) ? 5'h00 : wr_ptr_ff + 5'h01;
			count_ff  <= (count_ff == `HIST_DEPTH_W) ? count_ff : count_ff + 5'h01;
		end
	end

	assign hist_count_out = count_ff;

	always @(posedge sys_clk_in) begin
		if (sys_rst_in) begin
			hist_valid_out    <= 1'b0;
			hist_number_out   <= 7'h00;
			hist_location_out <= 7'h00;
		end else begin
			hist_valid_out    <= (hist_index_in < count_ff);
			hist_number_out   <= hist_mem[rd_addr][2*`ERR_NUM_W-1:`ERR_NUM_W];
			hist_location_out <= hist_mem[rd_addr][`ERR_NUM_W-1:0];
		end
	end

endmodule

// ---- test/seg_reader.sv ----
`timescale 1ns/1ns
`include "status_display_regs.vh"
module seg_reader (
	// Segments from the block
	input  wire [6:0]  seg_tens_in,
	input  wire [6:0]  seg_ones_in,
	// Two characters as an operator reads them
	output wire [15:0] text_out
);
	// Unknown patterns read as '?' so an X never passes for a digit
	function automatic [7:0] dec(input [6:0] s);
		case (s)
			`SEG_0: dec = "0";
			`SEG_1: dec = "1";
			`SEG_2: dec = "2";
			`SEG_3: dec = "3";
			`SEG_4: dec = "4";
			`SEG_5: dec = "5";
			`SEG_6: dec = "6";
			`SEG_7: dec = "7";
			`SEG_8: dec = "8";
			`SEG_9: dec = "9";
			`SEG_E: dec = "E";
			`SEG_R: dec = "r";
			`SEG_DASH: dec = "-";
			`SEG_BLANK: dec = " ";
			default: dec = "?";
		endcase
	endfunction
	assign text_out = {dec(seg_tens_in), dec(seg_ones_in)};
endmodule

// ---- test/status_error_display_sequencer_chk.sv ----
`timescale 1ns/1ns
`include "status_display_regs.vh"
module status_error_display_sequencer_chk #(
	parameter [`TICK_W-1:0] FRAME_CYCLES = 8
) (
	// Clock and reset
	input wire        sys_clk_in,
	input wire        sys_rst_in,
	// Events
	input wire        init_busy_in,
	input wire        err_valid_in,
	input wire        warn_valid_in,
	input wire        err_ack_in,
	input wire        supply_reset_only_error_in,
	input wire        err_cause_present_in,
	input wire [15:0] err_id_in,
	// Outputs watched
	input wire [6:0]  seg_tens_out,
	input wire [6:0]  seg_ones_out,
	input wire        error_pending_out,
	input wire        supply_reset_only_error_out,
	input wire [15:0] rec_id_out,
	input wire [4:0]  hist_count_out
);
	logic [31:0] cnt_ff;
	logic        ok_ff;
	logic        ban;
	assign ban = seg_tens_out == `SEG_E && seg_ones_out == `SEG_R;
	// Frame checks only while one error runs undisturbed; ack or init void them
	always @(posedge sys_clk_in) begin
		if (sys_rst_in || err_valid_in) begin
			cnt_ff <= 32'h0;
			ok_ff  <= !sys_rst_in;
		end else begin
			cnt_ff <= cnt_ff + 32'h1;
			if (err_ack_in || init_busy_in || !error_pending_out)
				ok_ff <= 1'b0;
		end
	end
	default clocking cb @(posedge sys_clk_in); endclocking
	default disable iff (sys_rst_in);
	sequence s_new_err;
		err_valid_in ##1 !init_busy_in;
	endsequence
	sequence s_ack;
		err_ack_in && error_pending_out && !supply_reset_only_error_out && !err_valid_in;
	endsequence
	a_reset_eights: assert property (disable iff (1'b0)
		sys_rst_in |=> seg_tens_out == `SEG_8 && seg_ones_out == `SEG_8 && !error_pending_out)
		else $error("display not 88 in reset");
	a_init_dash: assert property (
		init_busy_in |=> seg_tens_out == `SEG_DASH && seg_ones_out == `SEG_8)
		else $error("init code missing");
	a_error_pending: assert property (err_valid_in |=> error_pending_out)
		else $error("error not pending");
	a_error_banner: assert property (s_new_err |=> ban)
		else $error("banner not shown");
	a_banner_held: assert property (ok_ff && cnt_ff == FRAME_CYCLES |-> ban)
		else $error("banner left early");
	a_number_next: assert property (ok_ff && cnt_ff == FRAME_CYCLES + 1 |-> !ban)
		else $error("banner held too long");
	a_wrap_banner: assert property (ok_ff && cnt_ff == 3 * FRAME_CYCLES + 1 |-> ban)
		else $error("no return to banner");
	a_ack_clears: assert property (s_ack |=> !error_pending_out)
		else $error("ack did not clear");
	a_dotted_holds: assert property (
		error_pending_out && supply_reset_only_error_out |=> error_pending_out)
		else $error("dotted error cleared");
	a_relatch_dotted: assert property (
		!error_pending_out && err_cause_present_in && supply_reset_only_error_in
		|=> error_pending_out)
		else $error("dotted error not relatched");
	a_hist_step: assert property (err_valid_in && hist_count_out < 5'd20
		|=> hist_count_out == $past(hist_count_out) + 5'd1)
		else $error("history count wrong");
	a_record_take: assert property ((err_valid_in || warn_valid_in)
		|=> rec_id_out == $past(err_id_in))
		else $error("record id not captured");
endmodule
bind status_error_display_sequencer status_error_display_sequencer_chk #(
	.FRAME_CYCLES(FRAME_CYCLES)
) u_chk (.sys_clk_in, .sys_rst_in, .init_busy_in, .err_valid_in, .warn_valid_in, .err_ack_in,
	.supply_reset_only_error_in, .err_cause_present_in, .err_id_in, .seg_tens_out,
	.seg_ones_out, .error_pending_out, .supply_reset_only_error_out, .rec_id_out,
	.hist_count_out);

// ---- test/status_error_display_sequencer_tb_top.sv ----
`timescale 1ns/1ns
module status_error_display_sequencer_tb_top;
	localparam int F = 8;
	logic sys_clk_in = 1'b0, sys_rst_in = 1'b1;
	logic init_busy_in, dc_link_ok_in, stage_ready_in, switched_on_in, op_enabled_in;
	logic quick_stop_in, fault_reaction_in, safe_torque_off_in, stage_active_in;
	logic err_valid_in, warn_valid_in, err_ack_in, supply_reset_only_error_in;
	logic err_cause_present_in, dp_tens_out, dp_ones_out, error_pending_out;
	logic supply_reset_only_error_out, hist_valid_out;
	logic [6:0] err_number_in, err_location_in, seg_tens_out, seg_ones_out;
	logic [6:0] rec_location_out, hist_number_out, hist_location_out;
	logic [15:0] err_cause_in, err_remedy_in, err_id_in, err_comment_in, txt;
	logic [15:0] rec_cause_out, rec_remedy_out, rec_id_out, rec_comment_out;
	logic [31:0] err_time_in, rec_time_out;
	logic [4:0] hist_index_in, hist_count_out;
	logic [15:0] codes [8] = '{"-8", "88", "-6", "85", "4 ", "83", "52", "5 "};
	int mismatches = 0;
	int n_compared = 0;
	int hq[$], lq[$];
	int n, l;
	status_error_display_sequencer #(.FRAME_CYCLES(F)) dut (.*);
	seg_reader rd (.seg_tens_in(seg_tens_out), .seg_ones_in(seg_ones_out), .text_out(txt));
	initial forever #10 sys_clk_in = ~sys_clk_in;
	task tick(int k);
		repeat (k) @(negedge sys_clk_in);
	endtask
	task chk(logic [31:0] got, logic [31:0] exp);
		n_compared++;
		if (got !== exp) begin
			mismatches++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	function automatic logic [15:0] dd(int v);
		return {8'h30 + 8'(v / 10), 8'h30 + 8'(v % 10)};
	endfunction
	task setst(int k);
		{init_busy_in, fault_reaction_in, quick_stop_in, op_enabled_in, switched_on_in,
			stage_ready_in, dc_link_ok_in} = 7'(7'h40 >> k);
	endtask
	task raise(int a, int b, logic d);
		err_number_in = 7'(a);
		err_location_in = 7'(b);
		supply_reset_only_error_in = d;
		{err_id_in, err_cause_in, err_remedy_in, err_comment_in} = {$urandom, $urandom};
		err_time_in = $urandom;
		err_valid_in = 1'b1;
		tick(1);
		err_valid_in = 1'b0;
	endtask
	task end_of_test;
		$display("compared %0d mismatches %0d", n_compared, mismatches);
		if (mismatches == 0 && n_compared > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	// Whole run is about 130 cycles; this leaves ample margin
	initial begin
		#1000000;
		mismatches++;
		end_of_test();
	end
	initial begin
		{init_busy_in, dc_link_ok_in, stage_ready_in, switched_on_in, op_enabled_in,
			quick_stop_in, fault_reaction_in, safe_torque_off_in, stage_active_in,
			err_valid_in, warn_valid_in, err_ack_in, supply_reset_only_error_in,
			err_cause_present_in, hist_index_in} = '0;
		{err_number_in, err_location_in, err_id_in, err_cause_in, err_remedy_in,
			err_comment_in, err_time_in} = '0;
		void'($urandom(32'h3501BA57));
		tick(2);
		chk(txt, "88");
		chk({dp_tens_out, dp_ones_out, error_pending_out, hist_count_out}, 0);
		tick(6);
		sys_rst_in = 1'b0;
		$display("done: reset");
		for (int k = 0; k < 8; k++) begin
			setst(k);
			safe_torque_off_in = 1'($urandom);
			tick(1);
			chk(txt, codes[k]);
			chk({dp_tens_out, dp_ones_out}, k == 6 ? {1'b1, safe_torque_off_in} :
				k == 7 ? {safe_torque_off_in, 1'b0} : 2'b00);
		end
		setst(4);
		stage_active_in = 1'b1;
		n = 0;
		repeat (3 * F) begin
			tick(1);
			n += int'(dp_ones_out === 1'b1);
		end
		chk(n >= F && n <= 2 * F, 1);
		stage_active_in = 1'b0;
		setst(5);
		$display("done: states");
		// Second error lands mid-number, so the banner must restart
		repeat (2) begin
			n = $urandom_range(99);
			l = $urandom_range(99);
			raise(n, l, 1'b0);
			tick(1);
			chk({txt, dp_ones_out, error_pending_out, supply_reset_only_error_out},
				{"Er", 3'b010});
			tick(F - 1);
			chk(txt, "Er");
			tick(1);
			chk(txt, dd(n));
		end
		chk(rec_id_out, err_id_in);
		chk({rec_cause_out, rec_remedy_out}, {err_cause_in, err_remedy_in});
		chk({rec_comment_out, 9'h000, rec_location_out}, {err_comment_in, 9'h000, 7'(l)});
		chk(rec_time_out, err_time_in);
		tick(F);
		chk(txt, dd(l));
		tick(F);
		chk(txt, "Er");
		err_ack_in = 1'b1;
		tick(1);
		err_ack_in = 1'b0;
		chk(error_pending_out, 0);
		tick(1);
		chk(txt, "83");
		err_id_in = 16'($urandom);
		warn_valid_in = 1'b1;
		tick(1);
		warn_valid_in = 1'b0;
		chk({rec_id_out, error_pending_out}, {err_id_in, 1'b0});
		$display("done: error cycle");
		err_cause_present_in = 1'b1;
		raise(7, 1, 1'b1);
		err_ack_in = 1'b1;
		tick(1);
		err_ack_in = 1'b0;
		chk({txt, dp_ones_out, error_pending_out, supply_reset_only_error_out},
			{"Er", 3'b111});
		sys_rst_in = 1'b1;
		tick(2);
		sys_rst_in = 1'b0;
		tick(2);
		chk({txt, error_pending_out, supply_reset_only_error_out}, {"Er", 2'b11});
		{err_cause_present_in, supply_reset_only_error_in} = 2'b00;
		sys_rst_in = 1'b1;
		tick(2);
		sys_rst_in = 1'b0;
		tick(2);
		chk({txt, error_pending_out, supply_reset_only_error_out}, {"83", 2'b00});
		$display("done: dotted");
		err_valid_in = 1'b1;
		repeat (22) begin
			err_number_in = 7'($urandom_range(99));
			err_location_in = 7'($urandom_range(99));
			hq.push_front(err_number_in);
			lq.push_front(err_location_in);
			if (hq.size() > 20) begin
				void'(hq.pop_back());
				void'(lq.pop_back());
			end
			tick(1);
		end
		err_valid_in = 1'b0;
		chk(hist_count_out, 20);
		for (int i = 0; i <= 20; i++) begin
			hist_index_in = 5'(i);
			tick(1);
			chk(hist_valid_out, i < 20);
			if (i < 20) begin
				chk(hist_number_out, hq[i]);
				chk(hist_location_out, lq[i]);
			end
		end
		$display("done: history");
		end_of_test();
	end
endmodule
